// File: src/dll_lock_reset_control.sv
////////////////////////////////////////////////////////////////////////////
// How it works
// - Recovery bypass pin high: sample serial data on external clock rise.
// - Each of three clock inputs has a loop delaying it one period.
// - Bypass mode skips the loop search, used for low-rate clocking.
// - After reset each loop searches up to 3100 input clock cycles.
// - Transmit cell available stays low while transmit loop still searches.
// - Lock bit goes high once loop locks after system or soft reset.
// - Transmit cell available high means room for one more cell.
module dll_lock_reset_control #(
   parameter int LOCK_CYCLES = dll_ctrl_pkg::LOCK_CYCLES,
   parameter int TAP_W = dll_ctrl_pkg::TAP_W
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System clock inputs
   input wire logic receive_fifo_clock,
   input wire logic transmit_fifo_clock,
   input wire logic parallel_transmit_clock,
   // Serial receive
   input wire logic recovery_bypass_select,
   input wire logic external_recovered_clock,
   input wire logic serial_rx_data,
   output logic rx_bit,
   output logic rx_bit_valid,
   // Transmit FIFO side
   input wire logic tx_fifo_room,
   output logic transmit_cell_available,
   // Loop status
   output logic [2:0] dll_locked,
   output logic [2:0] core_clk_tick,
   output logic irq
);

   localparam int NPIN = 6;
   localparam int PIN_BYP = 5;
   localparam int PIN_DATA = 4;
   localparam int PIN_RCLK = 3;
   localparam int ND = dll_ctrl_pkg::NUM_DLL;

   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] st_q;
   logic [NPIN-1:0] agree;
   logic [NPIN-1:0] rise;

   logic [ND-1:0] byp_q;
   logic [ND-1:0] ctrl_hit;
   logic [ND-1:0] restart;
   logic [ND-1:0][TAP_W-1:0] tap;
   logic [ND-1:0] lock_prev_q;
   logic [ND-1:0] lock_rise;
   logic [ND-1:0] sts_q;
   logic [ND-1:0] mask_q;
   logic [ND-1:0] sts_clr;

   logic wr_en;
   logic rd_miss;
   logic [31:0] rd_data;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic rx_bit_q;
   logic rx_valid_q;
   logic cell_avail_q;
   logic irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; a change counts once stages two and three agree
   assign pins = {recovery_bypass_select, serial_rx_data,
                  external_recovered_clock, parallel_transmit_clock,
                  transmit_fifo_clock, receive_fifo_clock};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (agree & s3_q) | (~agree & st_q);
      end
   end

   // Only stages two and three feed the edge logic, never the first;
   // stage one may still be settling from a metastable capture
   assign agree = ~(s2_q ^ s3_q);
   assign rise = agree & s3_q & ~st_q;

   ////////////////////////////////////////////////////////////////////////
   // Register access strobe, taken in the access phase only
   assign wr_en = psel && penable && pwrite && pready_q && !pslverr_q;

   ////////////////////////////////////////////////////////////////////////
   // One lock loop per system clock input
   generate
      for (genvar i = 0; i < ND; i++) begin : g_dll
         assign ctrl_hit[i] = (paddr == dll_ctrl_pkg::ADDR_CTRL[i]);
         assign restart[i] = wr_en && ctrl_hit[i] &&
            pwdata[7:0] == dll_ctrl_pkg::CTRL_SOFT_RESET;

         // Bypass choice for low-rate modes; a zero write also clears it
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               byp_q[i] <= dll_ctrl_pkg::BYP_RESET[i];
            end else if (wr_en && ctrl_hit[i]) begin
               byp_q[i] <= pwdata[dll_ctrl_pkg::CTRL_BYP_BIT];
            end
         end

         dll_lock_search #(
            .LOCK_CYCLES(LOCK_CYCLES),
            .CNT_W(dll_ctrl_pkg::LOCK_CNT_W),
            .TAP_W(TAP_W)
         ) u_search (
            .pclk(pclk),
            .presetn(presetn),
            .restart(restart[i]),
            .bypass(byp_q[i]),
            .clk_rise(rise[i]),
            .locked_q(dll_locked[i]),
            .tick_q(core_clk_tick[i]),
            .tap_q(tap[i])
         );

         // Per-loop checks sit with the loop they watch
         chk_restart_drops: assert property (
            @(posedge pclk) disable iff (!presetn)
            restart[i] |=> !dll_locked[i])
            else $error("loop reset left lock bit high");

         chk_status_sticky: assert property (
            @(posedge pclk) disable iff (!presetn)
            sts_q[i] && !sts_clr[i] |=> sts_q[i])
            else $error("lock status bit lost without a clear");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Lock events, sticky status and mask
   assign lock_rise = dll_locked & ~lock_prev_q;
   assign sts_clr = (wr_en && paddr == dll_ctrl_pkg::ADDR_INT_STS) ?
                    pwdata[ND-1:0] : '0;

   // A lock arriving with its clear keeps the bit set,
   // so software cannot lose an event by clearing a stale one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_prev_q <= '0;
         sts_q <= '0;
      end else begin
         lock_prev_q <= dll_locked;
         sts_q <= (sts_q & ~sts_clr) | lock_rise;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= dll_ctrl_pkg::INT_MASK_RESET;
      end else if (wr_en && paddr == dll_ctrl_pkg::ADDR_INT_MASK) begin
         mask_q <= pwdata[ND-1:0];
      end
   end

   // Level interrupt, one cycle behind the status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and unmapped address decode
   // Unused bits read as zero; an unmapped hit returns zero as well
   always_comb begin
      rd_data = '0;
      rd_miss = 1'b1;
      for (int i = 0; i < ND; i++) begin
         if (ctrl_hit[i]) begin
            rd_data[dll_ctrl_pkg::CTRL_RUN_BIT] = dll_locked[i];
            rd_data[dll_ctrl_pkg::CTRL_BYP_BIT] = byp_q[i];
            rd_miss = 1'b0;
         end
      end
      if (paddr == dll_ctrl_pkg::ADDR_INT_STS) begin
         rd_data[ND-1:0] = sts_q;
         rd_miss = 1'b0;
      end
      if (paddr == dll_ctrl_pkg::ADDR_INT_MASK) begin
         rd_data[ND-1:0] = mask_q;
         rd_miss = 1'b0;
      end
      if (paddr == dll_ctrl_pkg::ADDR_DLL_TAP) begin
         rd_data = 32'(tap);
         rd_miss = 1'b0;
      end
   end

   // Answer is prepared in setup so every bus output is a flop
   // Zero wait states: the read value is frozen at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else if (psel && !penable) begin
         pready_q <= 1'b1;
         pslverr_q <= rd_miss;
         prdata_q <= pwrite ? '0 : rd_data;
      end else if (pready_q) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial receive sampling; internal recovery samples every cycle
   // Data crosses the same three stages as the clock, so the two stay aligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_bit_q <= 1'b0;
         rx_valid_q <= 1'b0;
      end else if (st_q[PIN_BYP]) begin
         rx_valid_q <= rise[PIN_RCLK];
         if (rise[PIN_RCLK]) begin
            rx_bit_q <= st_q[PIN_DATA];
         end
      end else begin
         rx_valid_q <= 1'b1;
         rx_bit_q <= st_q[PIN_DATA];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cell available: room in the FIFO and the transmit loop locked
   // Held low during the search since output timing is not yet met
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_avail_q <= 1'b0;
      end else begin
         cell_avail_q <= tx_fifo_room &&
            dll_locked[dll_ctrl_pkg::DLL_TF];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rx_bit = rx_bit_q;
   assign rx_bit_valid = rx_valid_q;
   assign transmit_cell_available = cell_avail_q;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_avail_needs_lock: assert property (
      $rose(cell_avail_q) |-> $past(dll_locked[dll_ctrl_pkg::DLL_TF]))
      else $error("cell available rose without transmit lock");

   chk_avail_room: assert property (
      cell_avail_q |-> $past(tx_fifo_room))
      else $error("cell available without FIFO room");

   chk_avail_follows: assert property (
      tx_fifo_room && dll_locked[dll_ctrl_pkg::DLL_TF] |=> cell_avail_q)
      else $error("cell available missing with room and lock");

   chk_avail_search: assert property (
      !dll_locked[dll_ctrl_pkg::DLL_TF] |=> !cell_avail_q)
      else $error("cell available high while transmit loop searches");

   chk_irq_masked_off: assert property (
      mask_q == '0 |=> !irq_q)
      else $error("interrupt raised with every source masked");

   chk_rx_internal: assert property (
      !st_q[PIN_BYP] |=> rx_bit_q == $past(st_q[PIN_DATA]))
      else $error("internal recovery sample missed");

   chk_mapped_ok: assert property (
      psel && !penable && !rd_miss |=> !pslverr_q)
      else $error("mapped address flagged as error");

   chk_soft_reset_clears: assert property (
      restart[dll_ctrl_pkg::DLL_RF] |=> !dll_locked[dll_ctrl_pkg::DLL_RF]
      [*3])
      else $error("lock bit not cleared by loop reset");

   chk_lock_sets_status: assert property (
      lock_rise[dll_ctrl_pkg::DLL_TF] |=> sts_q[dll_ctrl_pkg::DLL_TF])
      else $error("lock event lost from status");

   chk_irq_level: assert property (
      ##1 1 |-> irq_q == $past(|(sts_q & mask_q)))
      else $error("interrupt does not follow masked status");

   chk_ext_sample: assert property (
      st_q[PIN_BYP] && rise[PIN_RCLK] |=>
      rx_valid_q && rx_bit_q == $past(st_q[PIN_DATA]))
      else $error("external clock sample missed");

   chk_ext_idle: assert property (
      st_q[PIN_BYP] && !rise[PIN_RCLK] |=> !rx_valid_q)
      else $error("sample taken without external clock edge");

   chk_apb_answer: assert property (
      psel && !penable |=> pready_q ##1 !pready_q)
      else $error("bus answer not one cycle after setup");

   chk_unmapped_err: assert property (
      psel && !penable && rd_miss |=> pslverr_q)
      else $error("unmapped address not flagged");

   cov_tx_lock: cover property ($rose(dll_locked[dll_ctrl_pkg::DLL_TF]));
   cov_soft_reset: cover property (restart[dll_ctrl_pkg::DLL_TF]);
   cov_irq: cover property ($rose(irq_q));
   cov_ext_sample: cover property (st_q[PIN_BYP] && rise[PIN_RCLK]);
   cov_byp_lock: cover property (byp_q[dll_ctrl_pkg::DLL_PT] &&
      dll_locked[dll_ctrl_pkg::DLL_PT]);

endmodule

// File: shared/dll_ctrl_pkg.sv
package dll_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Loop numbering, one loop per system clock input
   localparam int NUM_DLL = 3;
   localparam int DLL_RF = 0;
   localparam int DLL_TF = 1;
   localparam int DLL_PT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RF_CTRL = 8'h96;
   localparam logic [7:0] IDX_TF_CTRL = 8'h9A;
   localparam logic [7:0] IDX_PT_CTRL = 8'h9E;
   localparam logic [7:0] IDX_INT_STS = 8'hA0;
   localparam logic [7:0] IDX_INT_MASK = 8'hA1;
   localparam logic [7:0] IDX_DLL_TAP = 8'hA2;

   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_RF_CTRL = {2'h0, IDX_RF_CTRL, 2'h0};
   localparam logic [11:0] ADDR_TF_CTRL = {2'h0, IDX_TF_CTRL, 2'h0};
   localparam logic [11:0] ADDR_PT_CTRL = {2'h0, IDX_PT_CTRL, 2'h0};
   localparam logic [11:0] ADDR_INT_STS = {2'h0, IDX_INT_STS, 2'h0};
   localparam logic [11:0] ADDR_INT_MASK = {2'h0, IDX_INT_MASK, 2'h0};
   localparam logic [11:0] ADDR_DLL_TAP = {2'h0, IDX_DLL_TAP, 2'h0};
   localparam logic [2:0][11:0] ADDR_CTRL =
      {ADDR_PT_CTRL, ADDR_TF_CTRL, ADDR_RF_CTRL};

   ////////////////////////////////////////////////////////////////////////
   // Loop control register fields and values
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_BYP_BIT = 1;
   localparam logic [7:0] CTRL_SOFT_RESET = 8'h00;
   localparam logic [2:0] BYP_RESET = 3'h0;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Lock search and delay measurement
   localparam int LOCK_CYCLES = 3100;
   localparam int LOCK_CNT_W = 12;
   localparam int TAP_W = 8;

endpackage

// File: src/dll_lock_search.sv
module dll_lock_search #(
   parameter int LOCK_CYCLES = dll_ctrl_pkg::LOCK_CYCLES,
   parameter int CNT_W = dll_ctrl_pkg::LOCK_CNT_W,
   parameter int TAP_W = dll_ctrl_pkg::TAP_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic restart,
   input wire logic bypass,
   input wire logic clk_rise,
   // Status
   output logic locked_q,
   output logic tick_q,
   output logic [TAP_W-1:0] tap_q
);

   typedef enum logic [1:0] {SEARCH, LOCKED, BYPASSED} dll_state_e;

   localparam logic [CNT_W-1:0] LAST_EDGE = CNT_W'(LOCK_CYCLES - 1);
   localparam logic [TAP_W-1:0] TAP_MAX = '1;
   localparam logic [TAP_W-1:0] TAP_ONE = TAP_W'(1);

   dll_state_e state_q;
   dll_state_e state_d;
   logic [CNT_W-1:0] edges_q;
   logic [TAP_W-1:0] period_q;
   logic [TAP_W-1:0] delay_q;

   ////////////////////////////////////////////////////////////////////////
   // Lock search: a restart always wins over any other move
   always_comb begin
      state_d = state_q;
      case (state_q)
         SEARCH: begin
            if (bypass) begin
               state_d = BYPASSED;
            end else if (clk_rise && edges_q == LAST_EDGE) begin
               state_d = LOCKED;
            end
         end
         LOCKED: if (bypass) state_d = BYPASSED;
         BYPASSED: if (!bypass) state_d = SEARCH;
         default: state_d = SEARCH;
      endcase
      if (restart) state_d = SEARCH;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SEARCH;
         locked_q <= 1'b0;
      end else begin
         state_q <= state_d;
         locked_q <= (state_d != SEARCH);
      end
   end

   // Input clock edges seen during the search
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edges_q <= '0;
      end else if (restart || state_q != SEARCH) begin
         edges_q <= '0;
      end else if (clk_rise) begin
         edges_q <= edges_q + 1'b1;
      end
   end

   // Period measure; saturates so a stopped clock cannot wrap the tap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q <= '0;
         tap_q <= '0;
      end else if (clk_rise) begin
         period_q <= TAP_ONE;
         tap_q <= period_q;
      end else if (period_q != TAP_MAX) begin
         period_q <= period_q + 1'b1;
      end
   end

   // Internal clock tick one measured period after each input edge; when bypassed, the tick follows each input edge directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_q <= '0;
         tick_q <= 1'b0;
      end else begin
         if (clk_rise) begin
            delay_q <= tap_q;
         end else if (delay_q != '0) begin
            delay_q <= delay_q - 1'b1;
         end
         if (state_q == BYPASSED) begin
            tick_q <= clk_rise;
         end else begin
            // Expiry meets the next rise on a steady clock; never mask it
            tick_q <= (delay_q == TAP_ONE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_bypass_lock: assert property (
      @(posedge pclk) disable iff (!presetn)
      bypass && !restart |=> locked_q)
      else $error("bypassed loop did not report lock");

   chk_lock_after_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_q == SEARCH && clk_rise && edges_q == LAST_EDGE &&
      !restart |=> locked_q)
      else $error("loop missed lock at end of search");

   chk_no_early_lock: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(locked_q) |-> $past(bypass) || $past(edges_q) == LAST_EDGE)
      else $error("lock reported before search completed");

endmodule

// File: testbench/clk_src_model.sv
module clk_src_model #(
   parameter int RF_NS = 80,
   parameter int TF_NS = 100,
   parameter int PT_NS = 120,
   parameter int EXT_NS = 100
) (
   // System clock inputs
   output logic receive_fifo_clock,
   output logic transmit_fifo_clock,
   output logic parallel_transmit_clock,
   // Serial receive line
   output logic external_recovered_clock,
   output logic serial_rx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   int seed = 32'hB4877C52;

   ////////////////////////////////////////////////////////////////////////
   // Clocks are stable from time zero, with offsets of 2 to 7 ns off the pclk grid
   initial begin
      receive_fifo_clock = 1'b0;
      #3;
      forever #(RF_NS / 2) receive_fifo_clock = ~receive_fifo_clock;
   end
   initial begin
      transmit_fifo_clock = 1'b0;
      #4;
      forever #(TF_NS / 2) transmit_fifo_clock = ~transmit_fifo_clock;
   end
   initial begin
      parallel_transmit_clock = 1'b0;
      #2;
      forever #(PT_NS / 2) parallel_transmit_clock = ~parallel_transmit_clock;
   end
   initial begin
      external_recovered_clock = 1'b0;
      #7;
      forever #(EXT_NS / 2)
         external_recovered_clock = ~external_recovered_clock;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data moves on the falling edge so it is steady around each rise
   initial serial_rx_data = 1'b0;
   always @(negedge external_recovered_clock) begin
      serial_rx_data = 1'($random(seed));
   end
endmodule

// File: testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, rfc, tfc, ptc, ext_clk, sdata;
   logic byp_sel = 1'b0, room = 1'b0, mon = 1'b0;
   logic rx_bit, rx_valid, cav, irq;
   logic [2:0] locked, tick;
   logic q[$];
   int n_fail = 0, total_checks = 0, seed = 32'hB4877C52, n;
   int per[3] = '{8, 10, 12};

   always #5 pclk = ~pclk;

   dll_lock_reset_control #(.LOCK_CYCLES(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .receive_fifo_clock(rfc), .transmit_fifo_clock(tfc),
      .parallel_transmit_clock(ptc), .recovery_bypass_select(byp_sel),
      .external_recovered_clock(ext_clk), .serial_rx_data(sdata),
      .rx_bit(rx_bit), .rx_bit_valid(rx_valid), .tx_fifo_room(room),
      .transmit_cell_available(cav), .dll_locked(locked),
      .core_clk_tick(tick), .irq(irq));

   clk_src_model u_src (
      .receive_fifo_clock(rfc), .transmit_fifo_clock(tfc),
      .parallel_transmit_clock(ptc), .external_recovered_clock(ext_clk),
      .serial_rx_data(sdata));

   ////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic give_verdict();
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic limit(input int c);
      if (c >= 3000) begin
         n_fail++;
         give_verdict();
      end
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
      int c;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (pready !== 1'b1 && c < 3000);
      limit(c);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_lock(input int i);
      n = 0;
      while (locked[i] !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      limit(n);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   // Counts edges up to the next internal clock tick of loop i
   task automatic wait_tick(input int i);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (tick[i] !== 1'b1 && n < 50);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Bypass data check: each external clock rise yields one sampled bit
   always @(posedge ext_clk) if (mon) q.push_back(sdata);
   always @(posedge pclk) begin
      if (mon && rx_valid === 1'b1) begin
         if (q.size() == 0) chk("rx_extra", 0, 1);
         else chk("rx_bit", q.pop_front(), rx_bit);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      room <= 1'b1;
      cyc(10);
      chk("lock_early", 0, locked);
      chk("avail_search", 0, cav);
      chk("rx_valid", 1, rx_valid);
      apb(0, dll_ctrl_pkg::ADDR_INT_MASK, 0);
      chk("mask_rst", 0, rd);
      for (int i = 0; i < 3; i++) wait_lock(i);
      apb(0, dll_ctrl_pkg::ADDR_INT_STS, 0);
      chk("sts_lock", 7, rd);
      cyc(2);
      chk("irq_masked", 0, irq);
      apb(1, dll_ctrl_pkg::ADDR_INT_MASK, 7);
      cyc(3);
      chk("irq_on", 1, irq);
      apb(1, dll_ctrl_pkg::ADDR_INT_STS, 7);
      cyc(3);
      chk("irq_clr", 0, irq);
      // Unmapped access is refused and leaves the mask alone
      apb(1, 12'h004, 0);
      chk("err_w", 1, err);
      apb(0, 12'h004, 0);
      chk("err_r", 1, err);
      chk("unmapped", 0, rd);
      apb(0, dll_ctrl_pkg::ADDR_INT_MASK, 0);
      chk("mask", 7, rd);
      // Measured periods and internal clock spacing
      apb(0, dll_ctrl_pkg::ADDR_DLL_TAP, 0);
      chk("tap", {8'h0, 8'd12, 8'd10, 8'd8}, rd);
      for (int i = 0; i < 3; i++) begin
         wait_tick(i);
         limit(n * 60);
         wait_tick(i);
         chk("tick_gap", per[i], n);
      end
      // Transmit cell available follows room once locked
      repeat (20) begin
         @(posedge pclk);
         room <= 1'($random(seed));
         cyc(2);
         chk("avail", room, cav);
      end
      @(posedge pclk);
      room <= 1'b1;
      // Soft reset of each loop; FIFO flush lives outside this block
      for (int i = 0; i < 3; i++) begin
         apb(1, dll_ctrl_pkg::ADDR_CTRL[i], dll_ctrl_pkg::CTRL_SOFT_RESET);
         cyc(1);
         chk("lock_rst", 7 & ~(1 << i), locked);
         if (i == 1) chk("avail_rst", 0, cav);
         wait_lock(i);
         chk("lock_time", 1, n >= 7 * per[i]);
         cyc(3);
         chk("irq_relock", 1, irq);
         apb(0, dll_ctrl_pkg::ADDR_INT_STS, 0);
         chk("sts_relock", 1 << i, rd);
         apb(1, dll_ctrl_pkg::ADDR_INT_STS, 1 << i);
      end
      // Low-rate bypass locks at once, clearing it restarts the search
      apb(1, dll_ctrl_pkg::ADDR_PT_CTRL, 0);
      apb(1, dll_ctrl_pkg::ADDR_PT_CTRL, 2);
      cyc(3);
      chk("lock_byp", 1, locked[2]);
      apb(0, dll_ctrl_pkg::ADDR_PT_CTRL, 0);
      chk("ctrl_byp", 3, rd);
      apb(1, dll_ctrl_pkg::ADDR_PT_CTRL, 0);
      cyc(2);
      chk("lock_unbyp", 0, locked[2]);
      wait_lock(2);
      // External recovered clock path
      @(posedge pclk);
      byp_sel <= 1'b1;
      cyc(10);
      @(negedge ext_clk);
      mon = 1'b1;
      repeat (20) @(posedge ext_clk);
      @(negedge ext_clk);
      mon = 1'b0;
      chk("rx_left", 0, q.size());
      give_verdict();
   end
endmodule
